// >>> hdl/fcrb_pkg.sv
/*
 * Constants and types for the busy/reject link-response builder.
 * Assumes the consumer refers to every item as fcrb_pkg::name.
 */
package fcrb_pkg;

    // ------------------------------------------------------------
    // field widths
    // ------------------------------------------------------------
    localparam int unsigned ID_W   = 24;
    localparam int unsigned FCTL_W = 24;
    localparam int unsigned CODE_W = 8;
    localparam int unsigned PRM_W  = 32;
    localparam int unsigned NCHK   = 16;

    // ------------------------------------------------------------
    // parameter field layout (busy and reject alike)
    // ------------------------------------------------------------
    localparam int unsigned PRM_ACT_LSB = 24;
    localparam int unsigned PRM_RSN_LSB = 16;
    localparam int unsigned PRM_RSV_LSB = 8;
    localparam int unsigned PRM_VND_LSB = 0;

    // ------------------------------------------------------------
    // frame control context bits
    // ------------------------------------------------------------
    localparam int unsigned FCTL_XCTX_BIT = 23;
    localparam int unsigned FCTL_SCTX_BIT = 22;

    // ------------------------------------------------------------
    // action codes
    // ------------------------------------------------------------
    localparam logic [7:0] ACT_RETRY   = 8'h01;
    localparam logic [7:0] ACT_NORETRY = 8'h02;
    localparam logic [7:0] BSY_ACT_END = 8'h01;
    localparam logic [7:0] BSY_ACT_OPN = 8'h02;

    // ------------------------------------------------------------
    // busy reason codes
    // ------------------------------------------------------------
    localparam logic [7:0] BSY_RSN_LOGIC  = 8'h01;
    localparam logic [7:0] BSY_RSN_RESRC  = 8'h03;
    localparam logic [7:0] RSN_VENDOR     = 8'hFF;

    // ------------------------------------------------------------
    // check vector: bit index = order of checking, reason per bit
    // ------------------------------------------------------------
    localparam int unsigned CHK_UNEXP_ACK = 6;
    localparam logic [7:0] CHK_REASON [NCHK] = '{
        8'h05, 8'h01, 8'h02, 8'h03, 8'h04, 8'h16, 8'h14, 8'h06,
        8'h07, 8'h0D, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'hFF};
    localparam logic [15:0] CHK_RETRY_MASK = 16'h803F;
    localparam logic [15:0] FAB_LC_MASK    = 16'h003F;
    localparam logic [15:0] PORT_LC_MASK   = 16'h0040;

    typedef enum logic [1:0] {
        FCRB_RSP_NONE,
        FCRB_RSP_P_BSY,
        FCRB_RSP_P_RJT,
        FCRB_RSP_F_RJT
    } fcrb_rsp_e;
endpackage

// >>> hdl/fcrb_hdr_swap.sv
/*
 * Header turnaround for a link response: id swap and context flip.
 * Assumes purely combinational use; the caller registers the result.
 */
`timescale 1ns/1ps
`default_nettype none

module fcrb_hdr_swap (
    // received header
    input  wire logic [fcrb_pkg::ID_W-1:0]   rx_d_id_i,
    input  wire logic [fcrb_pkg::ID_W-1:0]   rx_s_id_i,
    input  wire logic [fcrb_pkg::FCTL_W-1:0] rx_f_ctl_i,
    // response header
    output logic      [fcrb_pkg::ID_W-1:0]   tx_d_id_o,
    output logic      [fcrb_pkg::ID_W-1:0]   tx_s_id_o,
    output logic      [fcrb_pkg::FCTL_W-1:0] tx_f_ctl_o
);

    always_comb begin
        tx_d_id_o = rx_s_id_i;
        tx_s_id_o = rx_d_id_i;
        // other control bits are left clear; only the contexts matter
        tx_f_ctl_o = '0;
        tx_f_ctl_o[fcrb_pkg::FCTL_XCTX_BIT] = ~rx_f_ctl_i[fcrb_pkg::FCTL_XCTX_BIT];
        tx_f_ctl_o[fcrb_pkg::FCTL_SCTX_BIT] = ~rx_f_ctl_i[fcrb_pkg::FCTL_SCTX_BIT];
    end

endmodule

`default_nettype wire

// >>> hdl/fcrb_param_pack.sv
/*
 * Packs action, reason and vendor code into the 32-bit parameter word.
 * Assumes codes are already legal; reserved byte is forced to zero.
 */
`timescale 1ns/1ps
`default_nettype none

module fcrb_param_pack (
    // codes
    input  wire logic [fcrb_pkg::CODE_W-1:0] action_i,
    input  wire logic [fcrb_pkg::CODE_W-1:0] reason_i,
    input  wire logic [fcrb_pkg::CODE_W-1:0] vendor_i,
    // packed word
    output logic      [fcrb_pkg::PRM_W-1:0]  param_o
);

    always_comb begin
        param_o = '0;
        param_o[fcrb_pkg::PRM_ACT_LSB +: fcrb_pkg::CODE_W] = action_i;
        param_o[fcrb_pkg::PRM_RSN_LSB +: fcrb_pkg::CODE_W] = reason_i;
        param_o[fcrb_pkg::PRM_VND_LSB +: fcrb_pkg::CODE_W] = vendor_i;
    end

endmodule

`default_nettype wire

// >>> hdl/fcrb_link_rsp.sv
/*
 * Busy / reject link-response decision and header builder.
 * Takes one parsed received header with its check results per
 * accepted cycle and returns at most one response header, or a
 * discard or abort-sequence pulse.
 * Assumes the frame parser supplies class, frame kind, exchange
 * validity and an ordered vector of check failures, and that the
 * transmit path holds ready while it takes a response.
 */
//
// Behaviour
// - busy action 01 ends sequence, interlocked only
// - class 2 busy otherwise action 02, normal end
// - busy action in word 5 bits 31-24
// - busy reason only 01h, 03h or FFh
// - reject denies delivery, carries code word
// - class 2 data frame error gets reject
// - fabric rejects control frames for six reasons
// - port rejects control only unexpected ACK, action 2
// - other control error, valid exchange: port aborts sequence, fabric discards
// - control error, invalid exchange: silent discard
// - class 3 rejectable frames discarded, no reply
// - never reject a reject; discard it
// - reject swaps source and destination ids
// - reject inverts exchange and sequence context bits
// - sequence id and count copied unchanged
// - data field dropped from response
// - reject code word: action, reason, reserved, vendor
// - first detected error is reported
// - busy code word uses same layout
// - no busy to control or busy frames
// - reject action 01 retryable, 02 not
`timescale 1ns/1ps
`default_nettype none

module fcrb_link_rsp #(
    parameter int unsigned NCHK = fcrb_pkg::NCHK
) (
    // clock and reset
    input  wire logic                         ref_clk_i,
    input  wire logic                         rst_n_i,
    // role
    input  wire logic                         fabric_mode_i,
    // received frame header
    input  wire logic                         frm_valid_i,
    output logic                              frm_ready_o,
    input  wire logic [fcrb_pkg::ID_W-1:0]    frm_d_id_i,
    input  wire logic [fcrb_pkg::ID_W-1:0]    frm_s_id_i,
    input  wire logic [fcrb_pkg::FCTL_W-1:0]  frm_f_ctl_i,
    input  wire logic [7:0]                   frm_seq_id_i,
    input  wire logic [15:0]                  frm_seq_cnt_i,
    input  wire logic [15:0]                  frm_ox_id_i,
    input  wire logic [15:0]                  frm_rx_id_i,
    input  wire logic                         frm_class3_i,
    input  wire logic                         frm_link_ctl_i,
    input  wire logic                         frm_is_rjt_i,
    input  wire logic                         frm_is_bsy_i,
    input  wire logic                         frm_xid_assign_i,
    input  wire logic                         frm_xchg_valid_i,
    // checks and busy request
    input  wire logic [NCHK-1:0]              chk_fail_i,
    input  wire logic                         busy_req_i,
    input  wire logic                         busy_end_seq_i,
    input  wire logic [fcrb_pkg::CODE_W-1:0]  busy_reason_i,
    input  wire logic [fcrb_pkg::CODE_W-1:0]  vendor_code_i,
    // response header
    output logic                              rsp_valid_o,
    input  wire logic                         rsp_ready_i,
    output fcrb_pkg::fcrb_rsp_e               rsp_kind_o,
    output logic [fcrb_pkg::ID_W-1:0]         rsp_d_id_o,
    output logic [fcrb_pkg::ID_W-1:0]         rsp_s_id_o,
    output logic [fcrb_pkg::FCTL_W-1:0]       rsp_f_ctl_o,
    output logic [7:0]                        rsp_seq_id_o,
    output logic [15:0]                       rsp_seq_cnt_o,
    output logic [15:0]                       rsp_ox_id_o,
    output logic [15:0]                       rsp_rx_id_o,
    output logic [fcrb_pkg::PRM_W-1:0]        rsp_param_o,
    output logic                              rsp_eof_term_o,
    // other outcomes
    output logic                              discard_o,
    output logic                              abort_seq_o
);

    // ------------------------------------------------------------
    // handshake state
    // ------------------------------------------------------------
    typedef enum logic {
        FCRB_ST_IDLE,
        FCRB_ST_HOLD
    } fcrb_st_e;

    fcrb_st_e state_q;
    fcrb_st_e state_d;
    logic     accept;

    assign accept = frm_valid_i && frm_ready_o;

    // ------------------------------------------------------------
    // first failing check
    // ------------------------------------------------------------
    logic [NCHK-1:0]               first_oh;
    logic [$clog2(NCHK)-1:0]       first_idx;
    logic                          err_any;

    always_comb begin
        first_oh  = '0;
        first_idx = '0;
        // lowest index is checked first; later hits are masked
        for (int i = NCHK - 1; i >= 0; i--) begin
            if (chk_fail_i[i]) begin
                first_oh  = '0;
                first_oh[i] = 1'b1;
                first_idx = i[$clog2(NCHK)-1:0];
            end
        end
        err_any = |chk_fail_i;
    end

    // ------------------------------------------------------------
    // outcome decision
    // ------------------------------------------------------------
    logic                          do_rjt;
    logic                          do_bsy;
    logic                          do_drop;
    logic                          do_abort;
    logic                          lc_allowed;

    always_comb begin
        do_rjt   = 1'b0;
        do_bsy   = 1'b0;
        do_drop  = 1'b0;
        do_abort = 1'b0;
        lc_allowed = fabric_mode_i ? |(first_oh & fcrb_pkg::FAB_LC_MASK[NCHK-1:0])
                                   : |(first_oh & fcrb_pkg::PORT_LC_MASK[NCHK-1:0]);
        if (frm_is_rjt_i) begin
            do_drop = err_any || busy_req_i;
        end else if (frm_class3_i) begin
            do_drop = err_any || busy_req_i;
        end else if (err_any) begin
            if (!frm_link_ctl_i) begin
                do_rjt = 1'b1;
            end else if (lc_allowed) begin
                do_rjt = 1'b1;
            end else if (!fabric_mode_i && frm_xchg_valid_i) begin
                do_abort = 1'b1;
            end else begin
                do_drop = 1'b1;
            end
        end else if (busy_req_i) begin
            // a port busy only answers class 2 data frames
            if (frm_link_ctl_i || frm_is_bsy_i || fabric_mode_i) begin
                do_drop = 1'b1;
            end else begin
                do_bsy = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // code selection
    // ------------------------------------------------------------
    logic [fcrb_pkg::CODE_W-1:0]   rjt_reason;
    logic [fcrb_pkg::CODE_W-1:0]   rjt_action;
    logic [fcrb_pkg::CODE_W-1:0]   bsy_reason;
    logic [fcrb_pkg::CODE_W-1:0]   bsy_action;
    logic                          bsy_term;
    logic [fcrb_pkg::CODE_W-1:0]   act_sel;
    logic [fcrb_pkg::CODE_W-1:0]   rsn_sel;
    logic [fcrb_pkg::CODE_W-1:0]   vnd_sel;

    always_comb begin
        rjt_reason = fcrb_pkg::CHK_REASON[first_idx];
        rjt_action = fcrb_pkg::CHK_RETRY_MASK[first_idx] ? fcrb_pkg::ACT_RETRY
                                                         : fcrb_pkg::ACT_NORETRY;
        if (frm_link_ctl_i && !fabric_mode_i) begin
            rjt_action = fcrb_pkg::ACT_NORETRY;
        end
    end

    always_comb begin
        // the terminating form is only legal on an id-assigning interlocked frame
        bsy_term   = busy_end_seq_i && frm_xid_assign_i;
        bsy_action = bsy_term ? fcrb_pkg::BSY_ACT_END : fcrb_pkg::BSY_ACT_OPN;
        // reserved reasons never leave; fall back to plain logic-busy
        if (busy_reason_i == fcrb_pkg::BSY_RSN_RESRC ||
            busy_reason_i == fcrb_pkg::RSN_VENDOR) begin
            bsy_reason = busy_reason_i;
        end else begin
            bsy_reason = fcrb_pkg::BSY_RSN_LOGIC;
        end
    end

    always_comb begin
        act_sel = do_bsy ? bsy_action : rjt_action;
        rsn_sel = do_bsy ? bsy_reason : rjt_reason;
        // vendor byte only means something with the vendor reason
        vnd_sel = (rsn_sel == fcrb_pkg::RSN_VENDOR) ? vendor_code_i : '0;
    end

    // ------------------------------------------------------------
    // header and parameter word
    // ------------------------------------------------------------
    logic [fcrb_pkg::ID_W-1:0]     sw_d_id;
    logic [fcrb_pkg::ID_W-1:0]     sw_s_id;
    logic [fcrb_pkg::FCTL_W-1:0]   sw_f_ctl;
    logic [fcrb_pkg::PRM_W-1:0]    prm_word;

    fcrb_hdr_swap u_swap (
        .rx_d_id_i  (frm_d_id_i),
        .rx_s_id_i  (frm_s_id_i),
        .rx_f_ctl_i (frm_f_ctl_i),
        .tx_d_id_o  (sw_d_id),
        .tx_s_id_o  (sw_s_id),
        .tx_f_ctl_o (sw_f_ctl)
    );

    fcrb_param_pack u_pack (
        .action_i (act_sel),
        .reason_i (rsn_sel),
        .vendor_i (vnd_sel),
        .param_o  (prm_word)
    );

    // ------------------------------------------------------------
    // handshake state machine
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            FCRB_ST_IDLE: begin
                if (accept && (do_rjt || do_bsy)) begin
                    state_d = FCRB_ST_HOLD;
                end
            end
            FCRB_ST_HOLD: begin
                if (rsp_ready_i) begin
                    state_d = FCRB_ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= FCRB_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // no new frame is taken while a response waits
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frm_ready_o <= 1'b0;
        end else begin
            frm_ready_o <= (state_d == FCRB_ST_IDLE);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rsp_valid_o <= 1'b0;
        end else begin
            rsp_valid_o <= (state_d == FCRB_ST_HOLD);
        end
    end

    // ------------------------------------------------------------
    // response header registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rsp_kind_o <= fcrb_pkg::FCRB_RSP_NONE;
        end else if (accept && do_bsy) begin
            rsp_kind_o <= fcrb_pkg::FCRB_RSP_P_BSY;
        end else if (accept && do_rjt) begin
            rsp_kind_o <= fabric_mode_i ? fcrb_pkg::FCRB_RSP_F_RJT
                                        : fcrb_pkg::FCRB_RSP_P_RJT;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rsp_d_id_o  <= '0;
            rsp_s_id_o  <= '0;
            rsp_f_ctl_o <= '0;
        end else if (accept && (do_rjt || do_bsy)) begin
            rsp_d_id_o  <= sw_d_id;
            rsp_s_id_o  <= sw_s_id;
            rsp_f_ctl_o <= sw_f_ctl;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rsp_seq_id_o  <= '0;
            rsp_seq_cnt_o <= '0;
            rsp_ox_id_o   <= '0;
            rsp_rx_id_o   <= '0;
        end else if (accept && (do_rjt || do_bsy)) begin
            rsp_seq_id_o  <= frm_seq_id_i;
            rsp_seq_cnt_o <= frm_seq_cnt_i;
            rsp_ox_id_o   <= frm_ox_id_i;
            rsp_rx_id_o   <= frm_rx_id_i;
        end
    end

    // header only: any received payload never reaches this block
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rsp_param_o <= '0;
        end else if (accept && (do_rjt || do_bsy)) begin
            rsp_param_o <= prm_word;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rsp_eof_term_o <= 1'b0;
        end else if (accept && (do_rjt || do_bsy)) begin
            rsp_eof_term_o <= do_bsy && bsy_term;
        end
    end

    // ------------------------------------------------------------
    // discard and abort pulses
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            discard_o   <= 1'b0;
            abort_seq_o <= 1'b0;
        end else begin
            discard_o   <= accept && do_drop;
            abort_seq_o <= accept && do_abort;
        end
    end

endmodule

`default_nettype wire

// >>> testbench/fcrb_link_rsp_properties.sv
/* Concurrent properties for fcrb_link_rsp.
   Assumes binding to the design top; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module fcrb_link_rsp_chk #(
    parameter int unsigned NCHK = 16
) (
    // clock and reset
    input wire logic                ref_clk_i,
    input wire logic                rst_n_i,
    // received frame
    input wire logic                fabric_mode_i,
    input wire logic                frm_valid_i,
    input wire logic                frm_ready_o,
    input wire logic [23:0]         frm_d_id_i,
    input wire logic [23:0]         frm_s_id_i,
    input wire logic [23:0]         frm_f_ctl_i,
    input wire logic [7:0]          frm_seq_id_i,
    input wire logic [15:0]         frm_seq_cnt_i,
    input wire logic                frm_class3_i,
    input wire logic                frm_link_ctl_i,
    input wire logic                frm_is_rjt_i,
    input wire logic                frm_is_bsy_i,
    input wire logic                frm_xchg_valid_i,
    // outcomes
    input wire logic                rsp_valid_o,
    input wire logic [1:0]          rsp_kind_o,
    input wire logic [23:0]         rsp_d_id_o,
    input wire logic [23:0]         rsp_s_id_o,
    input wire logic [23:0]         rsp_f_ctl_o,
    input wire logic [7:0]          rsp_seq_id_o,
    input wire logic [15:0]         rsp_seq_cnt_o,
    input wire logic [31:0]         rsp_param_o,
    input wire logic                rsp_eof_term_o,
    input wire logic                discard_o,
    input wire logic                abort_seq_o
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic       take     = frm_valid_i && frm_ready_o;
    wire logic [1:0] ctx_in   = frm_f_ctl_i[23:22];
    wire logic       no_bsy   = frm_link_ctl_i || frm_is_bsy_i || fabric_mode_i;
    wire logic       abort_ok = take && frm_link_ctl_i && frm_xchg_valid_i && !fabric_mode_i;
    wire logic       is_bsy   = rsp_kind_o == fcrb_pkg::FCRB_RSP_P_BSY;
    wire logic       is_prjt  = rsp_kind_o == fcrb_pkg::FCRB_RSP_P_RJT;

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_outcome_has_cause: assert property (($rose(rsp_valid_o) || discard_o || abort_seq_o) |-> $past(take))
        else $error("outcome without a taken frame");
    a_one_outcome_only: assert property ($onehot0({$rose(rsp_valid_o), discard_o, abort_seq_o}))
        else $error("more than one outcome for a frame");
    a_ids_swapped: assert property ($rose(rsp_valid_o) |-> rsp_d_id_o == $past(frm_s_id_i) && rsp_s_id_o == $past(frm_d_id_i))
        else $error("response ids not swapped");
    a_context_flipped: assert property ($rose(rsp_valid_o) |-> rsp_f_ctl_o[23:22] == ~$past(ctx_in))
        else $error("context bits not inverted");
    a_seq_fields_copied: assert property ($rose(rsp_valid_o) |-> rsp_seq_id_o == $past(frm_seq_id_i) && rsp_seq_cnt_o == $past(frm_seq_cnt_i))
        else $error("sequence fields not copied");
    a_quiet_class3_rjt: assert property (take && (frm_class3_i || frm_is_rjt_i) |=> !rsp_valid_o)
        else $error("response to class 3 or reject frame");
    a_no_busy_control: assert property ($rose(rsp_valid_o) && is_bsy |-> !$past(no_bsy))
        else $error("busy to control, busy frame or as fabric");
    a_busy_action_eof: assert property ($rose(rsp_valid_o) && is_bsy |-> rsp_param_o[31:24] == (rsp_eof_term_o ? 8'h01 : 8'h02))
        else $error("busy action and delimiter disagree");
    a_param_reserved: assert property (rsp_valid_o |-> rsp_param_o[15:8] == 8'h00)
        else $error("reserved parameter byte not zero");
    a_ctl_reject_act: assert property ($rose(rsp_valid_o) && is_prjt && $past(frm_link_ctl_i) |-> rsp_param_o[31:24] == 8'h02)
        else $error("port control reject not action 2");
    a_abort_cause: assert property (abort_seq_o |-> $past(abort_ok))
        else $error("abort without valid-exchange control frame");

    c_busy: cover property ($rose(rsp_valid_o) && is_bsy);
    c_discard: cover property (discard_o);
    c_abort: cover property (abort_seq_o);
endmodule

bind fcrb_link_rsp fcrb_link_rsp_chk #(.NCHK(NCHK)) u_chk (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .fabric_mode_i(fabric_mode_i),
    .frm_valid_i(frm_valid_i), .frm_ready_o(frm_ready_o), .frm_d_id_i(frm_d_id_i),
    .frm_s_id_i(frm_s_id_i), .frm_f_ctl_i(frm_f_ctl_i), .frm_seq_id_i(frm_seq_id_i),
    .frm_seq_cnt_i(frm_seq_cnt_i), .frm_class3_i(frm_class3_i), .frm_link_ctl_i(frm_link_ctl_i),
    .frm_is_rjt_i(frm_is_rjt_i), .frm_is_bsy_i(frm_is_bsy_i), .frm_xchg_valid_i(frm_xchg_valid_i),
    .rsp_valid_o(rsp_valid_o), .rsp_kind_o(rsp_kind_o), .rsp_d_id_o(rsp_d_id_o),
    .rsp_s_id_o(rsp_s_id_o), .rsp_f_ctl_o(rsp_f_ctl_o), .rsp_seq_id_o(rsp_seq_id_o),
    .rsp_seq_cnt_o(rsp_seq_cnt_o), .rsp_param_o(rsp_param_o), .rsp_eof_term_o(rsp_eof_term_o),
    .discard_o(discard_o), .abort_seq_o(abort_seq_o));
`default_nettype wire

// >>> testbench/fcrb_tx_model.sv
/* Transmit-path model that takes link responses from the block.
   Assumes the bench sets the stall count; acts on falling edges. */
`timescale 1ns/1ps
`default_nettype none
module fcrb_tx_model (
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    // response handshake
    input  wire logic       rsp_valid_i,
    input  wire logic [3:0] stall_i,
    output var  logic       rsp_ready_o
);
    logic [3:0] wait_q;

    // ready lasts one cycle only, so a response is never taken twice
    always @(negedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_q      <= 4'h0;
            rsp_ready_o <= 1'b0;
        end else if (rsp_ready_o) begin
            rsp_ready_o <= 1'b0;
        end else if (rsp_valid_i && wait_q == stall_i) begin
            rsp_ready_o <= 1'b1;
            wait_q      <= 4'h0;
        end else if (rsp_valid_i) begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
/* Self-checking bench for fcrb_link_rsp.
   Assumes the transmit-path model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 1'b0, rst_n = 1'b0, fab = 1'b0, vld = 1'b0;
    logic [23:0] d_id = 24'h01_0203, s_id = 24'h0A_0B0C, fctl = 24'h40_0000;
    logic [7:0]  sq_id = 8'h5A, brsn = 8'h01, vnd = 8'hA5;
    logic [15:0] sq_cnt = 16'h1234, cv = 16'h0000;
    logic        c3 = 1'b0, lc = 1'b0, rj = 1'b0, bz = 1'b0, xa = 1'b0, xv = 1'b1, breq = 1'b0, bend = 1'b0;
    logic [3:0]  stall = 4'h3;
    logic        rdy, rrdy, rv, eof, dis, abt;
    logic [23:0] od, os, ofc;
    logic [7:0]  osid;
    logic [15:0] oscnt, oox, orx;
    logic [31:0] prm;
    fcrb_pkg::fcrb_rsp_e kind;
    int          miscompares = 0, n_checks = 0, cyc = 0;

    fcrb_link_rsp uut (.ref_clk_i(clk), .rst_n_i(rst_n), .fabric_mode_i(fab), .frm_valid_i(vld),
        .frm_ready_o(rdy), .frm_d_id_i(d_id), .frm_s_id_i(s_id), .frm_f_ctl_i(fctl),
        .frm_seq_id_i(sq_id), .frm_seq_cnt_i(sq_cnt), .frm_ox_id_i(16'h0011), .frm_rx_id_i(16'h0022),
        .frm_class3_i(c3), .frm_link_ctl_i(lc), .frm_is_rjt_i(rj), .frm_is_bsy_i(bz),
        .frm_xid_assign_i(xa), .frm_xchg_valid_i(xv), .chk_fail_i(cv), .busy_req_i(breq),
        .busy_end_seq_i(bend), .busy_reason_i(brsn), .vendor_code_i(vnd), .rsp_valid_o(rv),
        .rsp_ready_i(rrdy), .rsp_kind_o(kind), .rsp_d_id_o(od), .rsp_s_id_o(os), .rsp_f_ctl_o(ofc),
        .rsp_seq_id_o(osid), .rsp_seq_cnt_o(oscnt), .rsp_ox_id_o(oox), .rsp_rx_id_o(orx), .rsp_param_o(prm),
        .rsp_eof_term_o(eof), .discard_o(dis), .abort_seq_o(abt));
    fcrb_tx_model tx (.ref_clk_i(clk), .rst_n_i(rst_n), .rsp_valid_i(rv), .stall_i(stall), .rsp_ready_o(rrdy));

    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            results();
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic results();
        if (miscompares == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // present one frame at a falling edge; outcome {rsp, discard, abort}
    task automatic go(input logic [15:0] v, input logic [2:0] want);
        cv = v;
        for (int i = 0; i < 20 && (i == 0 || rdy !== 1'b1); i++) @(negedge clk);
        vld = 1'b1;
        @(negedge clk);
        vld = 1'b0;
        chk({rv, dis, abt, rdy}, {want, ~want[2]});
    endtask

    task automatic hdr(input logic [1:0] k, input logic [31:0] p, input logic e);
        chk(kind, k);
        chk({od, os}, {s_id, d_id});
        chk(ofc, {~fctl[23:22], 22'h00_0000});
        chk({osid, oscnt}, {sq_id, sq_cnt});
        chk({oox, orx}, 32'h0011_0022);
        chk(prm, p);
        chk(eof, e);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_data_reject();
        go(16'h0002, 3'b100);
        hdr(fcrb_pkg::FCRB_RSP_P_RJT, 32'h0101_0000, 1'b0);
        go(16'h0208, 3'b100);
        hdr(fcrb_pkg::FCRB_RSP_P_RJT, 32'h0103_0000, 1'b0);
        go(16'h0200, 3'b100);
        hdr(fcrb_pkg::FCRB_RSP_P_RJT, 32'h020D_0000, 1'b0);
    endtask

    task automatic s_fabric_ctl();
        logic [7:0] rsn [6] = '{8'h05, 8'h01, 8'h02, 8'h03, 8'h04, 8'h16};
        fab = 1'b1;
        lc = 1'b1;
        for (int i = 0; i < 6; i++) begin
            go(16'h0001 << i, 3'b100);
            hdr(fcrb_pkg::FCRB_RSP_F_RJT, {8'h01, rsn[i], 16'h0000}, 1'b0);
        end
        go(16'h0080, 3'b010);
        fab = 1'b0;
    endtask

    task automatic s_port_ctl();
        go(16'h0040, 3'b100);
        hdr(fcrb_pkg::FCRB_RSP_P_RJT, 32'h0214_0000, 1'b0);
        go(16'h0100, 3'b001);
        xv = 1'b0;
        go(16'h0100, 3'b010);
        xv = 1'b1;
        lc = 1'b0;
    endtask

    task automatic s_discards();
        c3 = 1'b1;
        go(16'h0002, 3'b010);
        c3 = 1'b0;
        rj = 1'b1;
        go(16'h0002, 3'b010);
        rj = 1'b0;
        go(16'h0000, 3'b000);
    endtask

    task automatic s_busy();
        stall = 4'h0;
        breq = 1'b1;
        bend = 1'b1;
        xa = 1'b1;
        brsn = 8'h03;
        go(16'h0000, 3'b100);
        hdr(fcrb_pkg::FCRB_RSP_P_BSY, 32'h0103_0000, 1'b1);
        xa = 1'b0;
        brsn = 8'hFF;
        go(16'h0000, 3'b100);
        hdr(fcrb_pkg::FCRB_RSP_P_BSY, 32'h02FF_00A5, 1'b0);
        brsn = 8'h05;
        go(16'h0000, 3'b100);
        hdr(fcrb_pkg::FCRB_RSP_P_BSY, 32'h0201_0000, 1'b0);
        lc = 1'b1;
        go(16'h0000, 3'b010);
        lc = 1'b0;
        bz = 1'b1;
        go(16'h0000, 3'b010);
        bz = 1'b0;
        c3 = 1'b1;
        go(16'h0000, 3'b010);
        c3 = 1'b0;
        breq = 1'b0;
    endtask

    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        s_data_reject();
        s_fabric_ctl();
        s_port_ctl();
        s_discards();
        s_busy();
        repeat (4) @(negedge clk);
        results();
    end
endmodule
`default_nettype wire
